//--- verilog/brm_defs.vh
// Constants for the binary rate multiplier
`ifndef BRM_DEFS_VH
`define BRM_DEFS_VH
`define BRM_WORD_W 5
`define BRM_PERIOD 32
`define BRM_FIFO_DEPTH 16
`define BRM_FIFO_AW 4
`define BRM_CNT_RST 5'h0_0
`define BRM_SEC_RATE_RST 5'h1_f
`define BRM_PRI_RATE_RST 5'h0_0
`endif

//--- verilog/brm_fifo.v
// Parameterised valid/ready FIFO
`timescale 1ns/1ps
module brm_fifo #(
	parameter W = 5,
	parameter DEPTH = 16,
	parameter AW = 4
) (
	input wire i_ref_clk,
	input wire i_rst_n,
	input wire i_in_valid,
	output wire o_in_ready,
	input wire [W-1:0] i_in_data,
	output wire o_out_valid,
	input wire i_out_ready,
	output wire [W-1:0] o_out_data
);
	reg [W-1:0] mem_q [0:DEPTH-1];
	reg [AW-1:0] wr_q;
	reg [AW-1:0] rd_q;
	reg [AW:0] cnt_q;
	wire push;
	wire pop;
	assign o_in_ready = (cnt_q != DEPTH[AW:0]);
	assign o_out_valid = (cnt_q != {(AW+1){1'b0}});
	assign push = i_in_valid & o_in_ready;
	assign pop = o_out_valid & i_out_ready;
	assign o_out_data = mem_q[rd_q];
	always @(posedge i_ref_clk) begin
		if (push) begin
			mem_q[wr_q] <= i_in_data;
		end
	end
	always @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			wr_q <= {AW{1'b0}};
			rd_q <= {AW{1'b0}};
			cnt_q <= {(AW+1){1'b0}};
		end else begin
			if (push) begin
				wr_q <= wr_q + {{(AW-1){1'b0}}, 1'b1};
			end
			if (pop) begin
				rd_q <= rd_q + {{(AW-1){1'b0}}, 1'b1};
			end
			if (push & ~pop) begin
				cnt_q <= cnt_q + {{AW{1'b0}}, 1'b1};
			end else if (pop & ~push) begin
				cnt_q <= cnt_q - {{AW{1'b0}}, 1'b1};
			end
		end
	end
endmodule // brm_fifo

//--- verilog/brm_rate_multiplier.v
// Five-bit binary rate multiplier with two gated phases and cascade
// Function
// - Pulses per 32 clocks equal rate word
// - Counter and primary gating on primary clock
// - Primary rate bits are active high
// - Secondary bits active low, secondary clock gates
// - Interlaced outputs OR into one train
// - Cascade inhibit and enable in, matching outs
// - Both clocks work up to 1MHz
`timescale 1ns/1ps
`include "brm_defs.vh"
module brm_rate_multiplier #(
	parameter W = `BRM_WORD_W,
	parameter DEPTH = `BRM_FIFO_DEPTH,
	parameter AW = `BRM_FIFO_AW
) (
	input wire i_ref_clk,
	input wire i_nrst,
	input wire i_primary_clk,
	input wire i_secondary_clk,
	input wire i_pri_rate_valid,
	output wire o_pri_rate_ready,
	input wire [W-1:0] i_primary_rate,
	input wire [W-1:0] i_secondary_rate_n,
	input wire i_first_stage_inhibit_in,
	input wire i_gate_chain_enable_in,
	output reg o_primary_out,
	output reg o_secondary_out,
	output reg o_next_first_stage_inhibit_out,
	output reg o_next_gate_chain_enable_out,
	output wire [W-1:0] o_count
);
	////////////////////////////////////////////////////////////////
	// Reset release
	reg rst_s1_q;
	reg rst_s2_q;
	always @(posedge i_ref_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			rst_s1_q <= 1'b0;
			rst_s2_q <= 1'b0;
		end else begin
			rst_s1_q <= 1'b1;
			rst_s2_q <= rst_s1_q;
		end
	end
	wire rst_n;
	assign rst_n = rst_s2_q;
	////////////////////////////////////////////////////////////////
	// Pin synchronisers, every pin but the primary rate FIFO inputs sampled twice
	// One pair per pin, so no pin waits on another
	reg pclk_s1_q;
	reg pclk_s2_q;
	reg sclk_s1_q;
	reg sclk_s2_q;
	reg inh_s1_q;
	reg inh_s2_q;
	reg ena_s1_q;
	reg ena_s2_q;
	reg [W-1:0] sec_s1_q;
	reg [W-1:0] sec_s2_q;
	always @(posedge i_ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			pclk_s1_q <= 1'b0;
			pclk_s2_q <= 1'b0;
		end else begin
			pclk_s1_q <= i_primary_clk;
			pclk_s2_q <= pclk_s1_q;
		end
	end
	always @(posedge i_ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			sclk_s1_q <= 1'b0;
			sclk_s2_q <= 1'b0;
		end else begin
			sclk_s1_q <= i_secondary_clk;
			sclk_s2_q <= sclk_s1_q;
		end
	end
	always @(posedge i_ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			inh_s1_q <= 1'b0;
			inh_s2_q <= 1'b0;
		end else begin
			inh_s1_q <= i_first_stage_inhibit_in;
			inh_s2_q <= inh_s1_q;
		end
	end
	always @(posedge i_ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			ena_s1_q <= 1'b0;
			ena_s2_q <= 1'b0;
		end else begin
			ena_s1_q <= i_gate_chain_enable_in;
			ena_s2_q <= ena_s1_q;
		end
	end
	// Secondary word resets to all ones, which gates nothing
	always @(posedge i_ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			sec_s1_q <= `BRM_SEC_RATE_RST;
			sec_s2_q <= `BRM_SEC_RATE_RST;
		end else begin
			sec_s1_q <= i_secondary_rate_n;
			sec_s2_q <= sec_s1_q;
		end
	end
	wire pclk_s;
	wire sclk_s;
	wire inh_s;
	wire ena_s;
	assign pclk_s = pclk_s2_q;
	assign sclk_s = sclk_s2_q;
	assign inh_s = inh_s2_q;
	assign ena_s = ena_s2_q;
	////////////////////////////////////////////////////////////////
	// Clock edge detection; 100 MHz sampling covers 1 MHz clocks easily
	reg pclk_d_q;
	reg sclk_d_q;
	always @(posedge i_ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			pclk_d_q <= 1'b0;
		end else begin
			pclk_d_q <= pclk_s;
		end
	end
	// A high secondary pin after reset gives one early edge; word already holds the pin value then
	always @(posedge i_ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			sclk_d_q <= 1'b0;
		end else begin
			sclk_d_q <= sclk_s;
		end
	end
	wire prise;
	wire srise;
	assign prise = pclk_s & ~pclk_d_q;
	assign srise = sclk_s & ~sclk_d_q;
	////////////////////////////////////////////////////////////////
	// Primary rate words buffered, taken once per counter period
	wire fifo_valid;
	wire [W-1:0] fifo_data;
	wire period_end;
	brm_fifo #(.W(W), .DEPTH(DEPTH), .AW(AW)) u_fifo (
		.i_ref_clk(i_ref_clk),
		.i_rst_n(rst_n),
		.i_in_valid(i_pri_rate_valid),
		.o_in_ready(o_pri_rate_ready),
		.i_in_data(i_primary_rate),
		.o_out_valid(fifo_valid),
		.i_out_ready(period_end),
		.o_out_data(fifo_data)
	);
	reg [W-1:0] pri_rate_q;
	////////////////////////////////////////////////////////////////
	// Counter chain, held while inhibited by upstream stage
	reg [W-1:0] cnt_q;
	wire cnt_adv;
	assign cnt_adv = prise & ~inh_s;
	wire period_last;
	assign period_last = &cnt_q;
	assign period_end = cnt_adv & period_last;
	always @(posedge i_ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_q <= `BRM_CNT_RST;
			pri_rate_q <= `BRM_PRI_RATE_RST;
		end else begin
			if (cnt_adv) begin
				cnt_q <= cnt_q + {{(W-1){1'b0}}, 1'b1};
			end
			// Word changes only at a period edge so each period counts exactly
			if (period_end & fifo_valid) begin
				pri_rate_q <= fifo_data;
			end
		end
	end
	assign o_count = cnt_q;
	////////////////////////////////////////////////////////////////
	// Gate selection: rate bit W-1-k owns states whose lowest zero is stage k
	reg [W-1:0] sel;
	reg lower_ones;
	integer k;
	always @* begin
		sel = {W{1'b0}};
		lower_ones = 1'b1;
		for (k = 0; k < W; k = k + 1) begin
			if (lower_ones && (cnt_q[k] == 1'b0)) begin
				sel[W-1-k] = 1'b1;
			end
			lower_ones = lower_ones & cnt_q[k];
		end
	end
	wire pri_hit;
	wire sec_hit;
	assign pri_hit = ena_s & ~inh_s & |(sel & pri_rate_q);
	assign sec_hit = ena_s & |(sel & ~sec_s2_q);
	////////////////////////////////////////////////////////////////
	// Output pulses, one reference cycle long, each on its own clock
	always @(posedge i_ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			o_primary_out <= 1'b0;
			o_secondary_out <= 1'b0;
		end else begin
			o_primary_out <= cnt_adv & pri_hit;
			// Distinct clock edges keep the two trains apart when ORed
			o_secondary_out <= srise & sec_hit;
		end
	end
	////////////////////////////////////////////////////////////////
	// Cascade outputs
	always @(posedge i_ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			o_next_first_stage_inhibit_out <= 1'b1;
			o_next_gate_chain_enable_out <= 1'b0;
		end else begin
			// Next stage counts only on our wrap, gates only on our unused state
			o_next_first_stage_inhibit_out <= inh_s | ~period_last;
			o_next_gate_chain_enable_out <= ena_s & period_last;
		end
	end
endmodule // brm_rate_multiplier

//--- test/brm_clk_src.sv
// Partner: antiphase primary and secondary clocks
`timescale 1ns/1ps
module brm_clk_src (
	output logic o_pclk,
	output logic o_sclk
);
	initial o_pclk = 1'h0;
	always #80 o_pclk = ~o_pclk;
	assign o_sclk = ~o_pclk;
endmodule // brm_clk_src

//--- test/brm_rate_multiplier_props.sv
// Checker for counting, gating and carry outputs
`timescale 1ns/1ps
module brm_props (
	input wire i_ref_clk,
	input wire i_nrst,
	input wire i_first_stage_inhibit_in,
	input wire o_primary_out,
	input wire o_secondary_out,
	input wire o_next_first_stage_inhibit_out,
	input wire o_next_gate_chain_enable_out,
	input wire [4:0] o_count
);
	default clocking @(posedge i_ref_clk); endclocking
	default disable iff (!i_nrst);
	property p_step; $changed(o_count) |-> o_count - $past(o_count) == 5'h0_1; endproperty
	a_step: assert property (p_step) else $error("step");
	property p_fire; o_primary_out |-> $changed(o_count) && $past(o_count) != 5'h1_f; endproperty
	a_fire: assert property (p_fire) else $error("stray");
	property p_clash; !(o_primary_out && o_secondary_out); endproperty
	a_clash: assert property (p_clash) else $error("clash");
	property p_one; o_primary_out |=> !o_primary_out; endproperty
	a_one: assert property (p_one) else $error("width");
	// Five cycles let the synchroniser settle
	property p_inh; i_first_stage_inhibit_in [*5] |-> $stable(o_count) && !o_primary_out; endproperty
	a_inh: assert property (p_inh) else $error("inhibit");
	property p_co; o_next_gate_chain_enable_out || !o_next_first_stage_inhibit_out
		|-> o_count == 5'h1_f || $past(o_count) == 5'h1_f; endproperty
	a_co: assert property (p_co) else $error("carry");
	c_pri: cover property (o_primary_out);
	c_sec: cover property (o_secondary_out);
	c_co: cover property (o_next_gate_chain_enable_out);
endmodule // brm_props
bind brm_rate_multiplier brm_props u_props (.i_ref_clk, .i_nrst, .i_first_stage_inhibit_in,
	.o_primary_out, .o_secondary_out, .o_next_first_stage_inhibit_out,
	.o_next_gate_chain_enable_out, .o_count);

//--- test/tb_top.sv
// Bench: FIFO fill and drain, pulse counts per period
`timescale 1ns/1ps
module tb_top;
	logic clk = 1'h0, nrst = 1'h0, vld = 1'h0, inh = 1'h1;
	logic [4:0] rate = 5'h0_0, srn = 5'h1_f, cnt;
	logic [4:0] tbl [8] = '{5'h0_0, 5'h0_1, 5'h0_2, 5'h0_4, 5'h0_8, 5'h1_0, 5'h1_5, 5'h1_f};
	wire pk, sk, rdy, po, so;
	int fail_count = 0, checks_done = 0, pn = 0, sn = 0, on = 0;
	always #5 clk = ~clk;
	always @(posedge clk) pn <= pn + (po === 1'b1);
	always @(posedge clk) sn <= sn + (so === 1'b1);
	always @(posedge clk) on <= on + ((po | so) === 1'b1);
	brm_clk_src u_src (.o_pclk(pk), .o_sclk(sk));
	brm_rate_multiplier uut (.i_ref_clk(clk), .i_nrst(nrst), .i_primary_clk(pk),
		.i_secondary_clk(sk), .i_pri_rate_valid(vld), .o_pri_rate_ready(rdy),
		.i_primary_rate(rate), .i_secondary_rate_n(srn), .i_first_stage_inhibit_in(inh),
		.i_gate_chain_enable_in(1'h1), .o_primary_out(po), .o_secondary_out(so),
		.o_next_first_stage_inhibit_out(), .o_next_gate_chain_enable_out(), .o_count(cnt));
	////////////////////////////////////////////////////////////////
	task automatic chk(input logic [31:0] seen, exp);
		checks_done++;
		if (seen !== exp) begin
			fail_count++;
			$display("mismatch %0t %h %h", $time, seen, exp);
		end
	endtask
	// Edge-sampled, so counters and state agree
	task automatic wrap();
		do @(posedge clk); while (cnt !== 5'h1_f);
		do @(posedge clk); while (cnt !== 5'h0_0);
	endtask
	task automatic push(input logic [4:0] v);
		rate <= v;
		vld <= 1'h1;
		do @(posedge clk); while (rdy !== 1'h1);
		vld <= 1'h0;
		@(posedge clk);
	endtask
	task automatic tally_and_finish();
		$display("checks %0d fails %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	initial begin
		int p0, s0, o0;
		repeat (16) @(posedge clk);
		nrst <= 1'h1;
		repeat (24) @(posedge clk);
		repeat (16) push(5'h0_7);
		chk(rdy, 0);
		chk(cnt, 0);
		inh <= 1'h0;
		repeat (16) wrap();
		$display("fifo test done");
		foreach (tbl[i]) begin
			push(tbl[i]);
			srn <= ~tbl[i];
			wrap();
			p0 = pn;
			s0 = sn;
			o0 = on;
			wrap();
			chk(pn - p0, tbl[i]);
			chk(sn - s0, tbl[i]);
			chk(on - o0, 2 * tbl[i]);
			$display("rate %h done", tbl[i]);
		end
		tally_and_finish();
	end
	initial begin
		#400us;
		fail_count++;
		tally_and_finish();
	end
endmodule // tb_top
